// *** rtl/fpc_pkg.sv ***
/*
  Package for the front panel controller: register map, field positions,
  reset values, timing constants, event codes and the state record.
  Assumes a 40 MHz management clock and 32-bit APB with byte addressing.
*/
package fpc_pkg;

  // timing, in the units they are specified in
  localparam int unsigned CLK_HZ      = 40_000_000;
  localparam int unsigned DEBOUNCE_MS = 25;
  localparam int unsigned IDENT_S     = 15;
  localparam int unsigned BLINK_HZ    = 1;

  localparam logic [31:0] DEBOUNCE_CYC = 32'(CLK_HZ / 1000 * DEBOUNCE_MS);
  localparam logic [31:0] IDENT_CYC    = 32'(CLK_HZ * IDENT_S);
  localparam logic [31:0] BLINK_CYC    = 32'(CLK_HZ / (2 * BLINK_HZ));

  // buttons, index into the debouncer bank
  localparam int NBTN    = 4;
  localparam int BTN_PWR = 0;
  localparam int BTN_RST = 1;
  localparam int BTN_NMI = 2;
  localparam int BTN_ID  = 3;

  // register byte offsets
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_HEALTH = 12'h008;
  localparam logic [11:0] OFS_IDENT  = 12'h00C;
  localparam logic [11:0] OFS_EVENT  = 12'h010;

  // control fields
  localparam int CTRL_LOCKOUT  = 0;
  localparam int CTRL_SECURE   = 1;
  localparam int CTRL_PWR_PROT = 2;
  localparam int CTRL_RST_PROT = 3;
  localparam int CTRL_INTR_EN  = 4;

  // health fields
  localparam int HLT_CRIT_THR  = 0;
  localparam int HLT_CRIT_ECC  = 1;
  localparam int HLT_CRIT_FSB  = 2;
  localparam int HLT_NCRIT_THR = 3;
  localparam int HLT_READY     = 4;
  localparam int HLT_DEGRADED  = 5;
  localparam int HLT_W         = 6;

  // identify command fields
  localparam int IDC_OFF   = 0;
  localparam int IDC_START = 1;

  // events, lower index wins arbitration so power goes first
  localparam int NEVT      = 8;
  localparam int EV_PWR    = 0;
  localparam int EV_CMOS   = 1;
  localparam int EV_PVIOL  = 2;
  localparam int EV_RST    = 3;
  localparam int EV_RVIOL  = 4;
  localparam int EV_NMI    = 5;
  localparam int EV_ID     = 6;
  localparam int EV_INTR   = 7;

  localparam logic [NEVT-1:0][7:0] EVT_TYPE = {8'h05, 8'h14, 8'h13, 8'h06, 8'h14, 8'h06, 8'h14, 8'h14};
  localparam logic [NEVT-1:0][7:0] EVT_OFS  = {8'h00, 8'h01, 8'h00, 8'h00, 8'h02, 8'h00, 8'h07, 8'h00};

  typedef enum logic {ID_OFF, ID_BLINK} fpc_ident_t;

  typedef struct packed {
    logic [NBTN-1:0]        deb;
    logic [NBTN-1:0][31:0]  cnt;
    logic                   lockout;
    logic                   pwr_prot;
    logic                   rst_prot;
    logic                   intr_en;
    logic [HLT_W-1:0]       health;
    logic                   secure;
    logic                   kbc_prev;
    logic                   lock_prev;
    logic                   dc_prev;
    logic                   intr_prev;
    fpc_ident_t             ident;
    logic [31:0]            ident_cnt;
    logic [31:0]            blink_cnt;
    logic                   blink;
    logic [NEVT-1:0]        pend;
    logic                   evt_valid;
    logic [7:0]             evt_type;
    logic [7:0]             evt_ofs;
    logic [15:0]            last_evt;
    logic                   pwr_drive;
    logic                   rst_drive;
    logic                   green;
    logic                   amber;
    logic                   id_led;
    logic [31:0]            prdata;
    logic                   pslverr;
  } fpc_state_t;

  localparam fpc_state_t FPC_STATE_RST = '0;

endpackage

// *** rtl/fpc_top.sv ***
/*
  Front panel controller: debounces the panel buttons, bridges power and
  reset to the chipset, raises panel events toward the event filter and
  drives the fault/status and chassis identify indicators; APB slave.
  Assumes all panel and chassis inputs are already synchronous to pclk.
*/
// Chosen here: the register addresses and the APB register port.
// Behaviour
// - low power input passes through unless locked
// - low reset input passes through unless locked
// - power plus reset, DC off: CMOS event
// - every button debounced for 25 ms
// - amber solid critical, blinking non-critical
// - green solid ready, blink ready and degraded, else off
// - critical from thresholds, ECC or bus errors
// - non-critical from thresholds or chassis intrusion
// - identify press from off blinks 15 s
// - press or command turns identify off
// - identify press logs type 14h offset 1h
// - intrusion state change logs an event
// - debounced power level goes straight out
// - protected power press: violation, no action
// - power action beats the reset button
// - reset press acts at once
// - protected reset press: violation, no reset
// - diagnostic press logs 13h offset 0h
// - secure cleared on power-down, command, unlock
`timescale 1ns/1ps
module fpc_top #(
  parameter logic [31:0] DEB_CYC = fpc_pkg::DEBOUNCE_CYC,
  parameter logic [31:0] ID_CYC  = fpc_pkg::IDENT_CYC,
  parameter logic [31:0] BLK_CYC = fpc_pkg::BLINK_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        power_button_in_n,
  input  wire logic        reset_button_in_n,
  input  wire logic        nmi_button_in_n,
  input  wire logic        ident_button_in_n,
  input  wire logic        dc_power_good,
  input  wire logic        kbc_secure,
  input  wire logic        panel_lock_signal,
  input  wire logic        intrusion_state,
  output logic             power_button_out_n,
  output logic             reset_button_out_n,
  output logic             fault_led_green,
  output logic             fault_led_amber,
  output logic             chassis_id_led,
  output logic             event_valid,
  output logic      [7:0]  event_sensor_type,
  output logic      [7:0]  event_offset
);
  import fpc_pkg::*;

  fpc_state_t             s_q;
  fpc_state_t             s_d;
  logic [NBTN-1:0]        raw_press;
  logic [NBTN-1:0]        deb_d;
  logic [NBTN-1:0]        press_rise;
  logic [NBTN-1:0][31:0]  cnt_d;
  logic [NEVT-1:0]        evt_set;
  logic [NEVT-1:0]        grant;
  logic                   found;
  logic                   setup;
  logic                   wr;
  logic                   cmd_off;
  logic                   cmd_start;
  logic                   crit;
  logic                   ncrit;

  assign raw_press = ~{ident_button_in_n, nmi_button_in_n, reset_button_in_n, power_button_in_n};

  // counter restarts on any bounce, so only a clean level flips the output
  for (genvar i = 0; i < NBTN; i++) begin : g_deb
    logic diff;
    logic full;
    assign diff          = raw_press[i] != s_q.deb[i];
    assign full          = s_q.cnt[i] == DEB_CYC - 32'h1;
    assign deb_d[i]      = (diff && full) ? raw_press[i] : s_q.deb[i];
    assign cnt_d[i]      = (diff && !full) ? s_q.cnt[i] + 32'h1 : 32'h0;
    assign press_rise[i] = diff && full && raw_press[i];
  end

  assign setup     = psel && !penable;
  assign wr        = psel && penable && pwrite && pstrb[0];
  assign cmd_off   = wr && (paddr == OFS_IDENT) && pwdata[IDC_OFF];
  assign cmd_start = wr && (paddr == OFS_IDENT) && pwdata[IDC_START];

  always_comb begin
    s_d     = s_q;
    evt_set = '0;
    grant   = '0;
    found   = 1'b0;
    crit    = 1'b0;
    ncrit   = 1'b0;

    s_d.deb = deb_d;
    s_d.cnt = cnt_d;

    // register writes take effect at the access edge, zero wait states
    if (wr) begin
      case (paddr)
        OFS_CTRL: begin
          s_d.lockout  = pwdata[CTRL_LOCKOUT];
          s_d.pwr_prot = pwdata[CTRL_PWR_PROT];
          s_d.rst_prot = pwdata[CTRL_RST_PROT];
          s_d.intr_en  = pwdata[CTRL_INTR_EN];
          if (pwdata[CTRL_SECURE] != s_q.secure) begin
            s_d.secure = pwdata[CTRL_SECURE];
          end
        end
        OFS_HEALTH: s_d.health = pwdata[HLT_W-1:0];
        default: ;
      endcase
    end

    // read data is latched in the setup phase so it leaves a flop
    if (setup) begin
      s_d.pslverr = 1'b0;
      case (paddr)
        OFS_CTRL:   s_d.prdata = {27'h0, s_q.intr_en, s_q.rst_prot, s_q.pwr_prot, s_q.secure, s_q.lockout};
        OFS_STATUS: s_d.prdata = {16'h0, s_q.pend, s_q.green, s_q.amber, s_q.ident == ID_BLINK,
                                  s_q.secure, s_q.deb};
        OFS_HEALTH: s_d.prdata = {26'h0, s_q.health};
        OFS_IDENT:  s_d.prdata = 32'h0;
        OFS_EVENT:  s_d.prdata = {16'h0, s_q.last_evt};
        default: begin
          s_d.prdata  = 32'h0;
          s_d.pslverr = 1'b1;
        end
      endcase
    end

    // secure mode: any clear first, a fresh lock request wins over it
    if ((s_q.dc_prev && !dc_power_good) || (s_q.lock_prev && !panel_lock_signal)) begin
      s_d.secure = 1'b0;
    end
    if (kbc_secure && !s_q.kbc_prev) begin
      s_d.secure = 1'b1;
    end
    s_d.kbc_prev  = kbc_secure;
    s_d.lock_prev = panel_lock_signal;
    s_d.dc_prev   = dc_power_good;
    s_d.intr_prev = intrusion_state;

    if (press_rise[BTN_PWR]) begin
      if (s_q.secure || s_q.pwr_prot) begin
        evt_set[EV_PVIOL] = 1'b1;
      end else begin
        evt_set[EV_PWR] = 1'b1;
      end
      if (!dc_power_good && s_q.deb[BTN_RST]) begin
        evt_set[EV_CMOS] = 1'b1;
      end
    end
    if (press_rise[BTN_RST]) begin
      if (s_q.secure || s_q.rst_prot) begin
        evt_set[EV_RVIOL] = 1'b1;
      end else begin
        evt_set[EV_RST] = 1'b1;
      end
    end
    evt_set[EV_NMI]  = press_rise[BTN_NMI];
    evt_set[EV_ID]   = press_rise[BTN_ID];
    evt_set[EV_INTR] = s_q.intr_en && (intrusion_state != s_q.intr_prev);

    // bridged outputs follow the debounced level with no software in the path
    s_d.pwr_drive = deb_d[BTN_PWR] && !s_d.lockout && !s_d.secure && !s_d.pwr_prot;
    s_d.rst_drive = deb_d[BTN_RST] && !s_d.lockout && !s_d.secure && !s_d.rst_prot
                    && !s_d.pwr_drive;

    // free-running blink base shared by both indicators
    if (s_q.blink_cnt == BLK_CYC - 32'h1) begin
      s_d.blink_cnt = 32'h0;
      s_d.blink     = !s_q.blink;
    end else begin
      s_d.blink_cnt = s_q.blink_cnt + 32'h1;
    end

    case (s_q.ident)
      ID_OFF: begin
        if (press_rise[BTN_ID] || (cmd_start && !cmd_off)) begin
          s_d.ident     = ID_BLINK;
          s_d.ident_cnt = 32'h0;
        end
      end
      ID_BLINK: begin
        if (press_rise[BTN_ID] || cmd_off) begin
          s_d.ident = ID_OFF;
        end else if (cmd_start) begin
          s_d.ident_cnt = 32'h0;
        end else if (s_q.ident_cnt == ID_CYC - 32'h1) begin
          s_d.ident = ID_OFF;
        end else begin
          s_d.ident_cnt = s_q.ident_cnt + 32'h1;
        end
      end
      default: s_d.ident = ID_OFF;
    endcase
    s_d.id_led = (s_d.ident == ID_BLINK) && s_d.blink;

    crit  = s_d.health[HLT_CRIT_THR] || s_d.health[HLT_CRIT_ECC] || s_d.health[HLT_CRIT_FSB];
    ncrit = s_d.health[HLT_NCRIT_THR] || intrusion_state;
    if (crit) begin
      s_d.amber = 1'b1;
      s_d.green = 1'b0;
    end else if (ncrit) begin
      s_d.amber = s_d.blink;
      s_d.green = 1'b0;
    end else if (s_d.health[HLT_READY]) begin
      s_d.amber = 1'b0;
      s_d.green = s_d.health[HLT_DEGRADED] ? s_d.blink : 1'b1;
    end else begin
      s_d.amber = 1'b0;
      s_d.green = 1'b0;
    end

    // one event per cycle to the filter; new events set after the grant clears
    for (int i = 0; i < NEVT; i++) begin
      if (!found && s_q.pend[i]) begin
        grant[i]     = 1'b1;
        found        = 1'b1;
        s_d.evt_type = EVT_TYPE[i];
        s_d.evt_ofs  = EVT_OFS[i];
        s_d.last_evt = {EVT_TYPE[i], EVT_OFS[i]};
      end
    end
    s_d.evt_valid = found;
    s_d.pend      = (s_q.pend & ~grant) | evt_set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= FPC_STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata             = s_q.prdata;
  assign pready             = 1'b1;
  assign pslverr            = s_q.pslverr;
  assign power_button_out_n = !s_q.pwr_drive;
  assign reset_button_out_n = !s_q.rst_drive;
  assign fault_led_green    = s_q.green;
  assign fault_led_amber    = s_q.amber;
  assign chassis_id_led     = s_q.id_led;
  assign event_valid        = s_q.evt_valid;
  assign event_sensor_type  = s_q.evt_type;
  assign event_offset       = s_q.evt_ofs;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence cmos_combo_s;
    press_rise[BTN_PWR] && !dc_power_good && s_q.deb[BTN_RST];
  endsequence

  sequence cmos_event_s;
    event_valid && event_sensor_type == 8'h14 && event_offset == 8'h07;
  endsequence

  sequence power_event_s;
    event_valid && event_sensor_type == 8'h14 && event_offset == 8'h00;
  endsequence

  sequence nmi_event_s;
    event_valid && event_sensor_type == 8'h13 && event_offset == 8'h00;
  endsequence

  sequence ident_event_s;
    event_valid && event_sensor_type == 8'h14 && event_offset == 8'h01;
  endsequence

  power_bridge_a: assert property (
    !power_button_out_n == (s_q.deb[BTN_PWR] && !s_q.lockout && !s_q.secure && !s_q.pwr_prot))
    else $error("power output does not follow debounced button");

  lockout_blocks_a: assert property (s_q.lockout |-> power_button_out_n && reset_button_out_n)
    else $error("lockout let a button through");

  power_first_a: assert property (!power_button_out_n |-> reset_button_out_n)
    else $error("reset driven while power active");

  cmos_clear_a: assert property (cmos_combo_s |-> ##[1:8] cmos_event_s)
    else $error("combined press with DC off gave no clear event");

  debounce_len_a: assert property (
    s_q.deb[BTN_PWR] != $past(s_q.deb[BTN_PWR]) |-> $past(s_q.cnt[BTN_PWR]) == DEB_CYC - 32'h1)
    else $error("debounced level changed before full interval");

  amber_crit_a: assert property (
    (s_q.health[HLT_CRIT_THR] || s_q.health[HLT_CRIT_ECC] || s_q.health[HLT_CRIT_FSB])
    |-> fault_led_amber && !fault_led_green)
    else $error("critical state not solid amber");

  green_ready_a: assert property (
    (s_q.health == (HLT_W)'(1 << HLT_READY) && !intrusion_state && $stable(intrusion_state))
    |-> fault_led_green && !fault_led_amber)
    else $error("ready system not solid green");

  ident_timeout_a: assert property (
    (s_q.ident == ID_BLINK && s_q.ident_cnt == ID_CYC - 32'h1 && !press_rise[BTN_ID] && !cmd_start)
    |=> s_q.ident == ID_OFF && !chassis_id_led)
    else $error("identify blink did not end on time");

  ident_off_a: assert property (cmd_off |=> s_q.ident == ID_OFF)
    else $error("identify command did not turn indicator off");

  power_protect_a: assert property (
    (press_rise[BTN_PWR] && (s_q.secure || s_q.pwr_prot) && !wr)
    |=> power_button_out_n && s_q.pend[EV_PVIOL])
    else $error("protected power press not turned into violation");

  // a lock line already held high must not mask the unlock, only a fresh lock request may
  secure_unlock_a: assert property (
    ($fell(panel_lock_signal) && !$rose(kbc_secure)) |=> !s_q.secure)
    else $error("secure mode survived panel unlock");

  power_event_a: assert property (s_q.pend[EV_PWR] |=> power_event_s)
    else $error("pending power event not sent first");

  nmi_event_a: assert property (press_rise[BTN_NMI] |-> ##[1:8] nmi_event_s)
    else $error("diagnostic press gave no interrupt event");

  ident_event_a: assert property (press_rise[BTN_ID] |-> ##[1:8] ident_event_s)
    else $error("identify press gave no button event");

  reset_protect_a: assert property (
    (press_rise[BTN_RST] && (s_q.secure || s_q.rst_prot) && !wr)
    |=> reset_button_out_n && s_q.pend[EV_RVIOL])
    else $error("protected reset press not turned into violation");

  intrusion_event_a: assert property (
    (s_q.intr_en && intrusion_state != s_q.intr_prev) |=> s_q.pend[EV_INTR])
    else $error("intrusion change not logged");

  intrusion_amber_a: assert property (
    (intrusion_state && $stable(intrusion_state) && !s_q.health[HLT_CRIT_THR]
     && !s_q.health[HLT_CRIT_ECC] && !s_q.health[HLT_CRIT_FSB])
    |-> !fault_led_green && fault_led_amber == s_q.blink)
    else $error("intrusion did not give blinking amber");

endmodule // fpc_top

// *** tb/fpc_panel.sv ***
/*
  Model of the far side: panel switch contacts, keyboard controller lock
  line and the chipset power input, which counts press edges.
  Assumes the bench sets press and lock_req just after a rising edge.
*/
`timescale 1ns/1ps
module fpc_panel (
  input  wire logic       pclk,
  input  wire logic [3:0] press,
  input  wire logic       lock_req,
  input  wire logic       power_button_out_n,
  output logic      [3:0] btn_n,
  output logic            kbc_secure,
  output int              chipset_presses
);
  logic prev_q;

  initial begin
    btn_n = 4'hF;
    kbc_secure = 1'b0;
    chipset_presses = 0;
    prev_q = 1'b1;
  end

  always @(posedge pclk) begin
    // open contacts sit at the pull-up level
    btn_n      <= ~press;
    kbc_secure <= lock_req;
    prev_q     <= power_button_out_n;
    // the chipset acts on the press edge only, never on release
    if (prev_q === 1'b1 && power_button_out_n === 1'b0) begin
      chipset_presses <= chipset_presses + 1;
    end
  end
endmodule // fpc_panel

// *** tb/tb_top.sv ***
/*
  Self-checking bench for the front panel controller: APB tasks, button
  presses through the panel model, event and indicator checks.
  Assumes short debounce, identify and blink counts set below.
*/
`timescale 1ns/1ps
module tb_top;
  import fpc_pkg::*;
  localparam logic [31:0] DEB = 32'h4;
  localparam logic [31:0] IDC = 32'h40;
  localparam logic [31:0] BLK = 32'h4;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0]  pb, btn_n;
  logic        lock_req, kbc, dc, plock, intr, pwr_n, rst_n, grn, amb, idl, ev_v;
  logic [7:0]  ev_t, ev_o;
  logic [15:0] evq [$];
  logic [10:0] ht [9] = '{11'h018, 11'h028, 11'h048, 11'h084, 11'h102, 11'h301, 11'h000, 11'h184, 11'h504};
  int          cp, err_total, n_tests, cyc;

  fpc_top #(.DEB_CYC(DEB), .ID_CYC(IDC), .BLK_CYC(BLK)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .power_button_in_n(btn_n[0]), .reset_button_in_n(btn_n[1]),
    .nmi_button_in_n(btn_n[2]), .ident_button_in_n(btn_n[3]), .dc_power_good(dc),
    .kbc_secure(kbc), .panel_lock_signal(plock), .intrusion_state(intr),
    .power_button_out_n(pwr_n), .reset_button_out_n(rst_n), .fault_led_green(grn),
    .fault_led_amber(amb), .chassis_id_led(idl), .event_valid(ev_v),
    .event_sensor_type(ev_t), .event_offset(ev_o));

  fpc_panel panel (.pclk(pclk), .press(pb), .lock_req(lock_req), .power_button_out_n(pwr_n),
    .btn_n(btn_n), .kbc_secure(kbc), .chipset_presses(cp));

  initial pclk = 1'b0;
  always #12.5 pclk = ~pclk;

  always @(posedge pclk) begin
    if (ev_v === 1'b1) evq.push_back({ev_t, ev_o});
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      summarize();
    end
  end

  task summarize;
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // request held until pready is seen high at a rising edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    logic e;
    apb(1'b1, a, d, e);
  endtask

  task rd(input logic [11:0] a, input logic [31:0] exp, input logic eexp);
    logic e;
    apb(1'b0, a, 32'h0, e);
    check(rdat, exp);
    check({31'h0, e}, {31'h0, eexp});
  endtask

  // a lock change needs two edges through the panel model and the edge detector, an unlock driven straight to the DUT only one
  task secure_is(input logic exp);
    logic e;
    repeat (3) @(posedge pclk);
    apb(1'b0, OFS_STATUS, 32'h0, e);
    check({31'h0, rdat[4]}, {31'h0, exp});
  endtask

  task ev(input logic [15:0] exp);
    int i;
    logic [15:0] g;
    i = 0;
    while (evq.size() == 0 && i < 40) begin
      @(posedge pclk);
      i++;
    end
    g = (evq.size() != 0) ? evq.pop_front() : 16'hXXXX;
    check({16'h0, g}, {16'h0, exp});
  endtask

  // outputs are checked while the buttons are still held
  task press(input logic [3:0] m, input logic ep, input logic er);
    @(posedge pclk);
    pb <= m;
    repeat (DEB + 4) @(posedge pclk);
    check({31'h0, pwr_n}, {31'h0, ep});
    check({31'h0, rst_n}, {31'h0, er});
    pb <= 4'h0;
    repeat (DEB + 6) @(posedge pclk);
  endtask

  // 0 off, 1 blinking, 2 solid, judged over 16 cycles
  task led_chk(input int s, input logic [31:0] exp);
    int n;
    n = 0;
    repeat (16) begin
      @(posedge pclk);
      if ((s == 0 ? grn : (s == 1 ? amb : idl)) === 1'b1) n++;
    end
    check((n == 0) ? 32'h0 : ((n == 16) ? 32'h2 : 32'h1), exp);
  endtask

  initial begin
    {presetn, psel, penable, pwrite, lock_req, intr} = '0;
    {paddr, pwdata, pb} = '0;
    {dc, plock} = 2'b11;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_CTRL, 32'h0, 1'b0);
    rd(OFS_HEALTH, 32'h0, 1'b0);
    rd(12'h014, 32'h0, 1'b1);
    @(posedge pclk);
    pb <= 4'h1;
    repeat (2) @(posedge pclk);
    pb <= 4'h0;
    repeat (DEB + 6) @(posedge pclk);
    check(32'(evq.size()), 32'h0);
    press(4'h1, 1'b0, 1'b1);
    ev(16'h1400);
    check(32'(cp), 32'h1);
    press(4'h7, 1'b0, 1'b1);
    ev(16'h1400);
    ev(16'h1402);
    ev(16'h1300);
    press(4'h2, 1'b1, 1'b0);
    ev(16'h1402);
    wr(OFS_CTRL, 32'h1);
    press(4'h3, 1'b1, 1'b1);
    evq.delete();
    wr(OFS_CTRL, 32'hC);
    press(4'h3, 1'b1, 1'b1);
    ev(16'h0600);
    ev(16'h0600);
    wr(OFS_CTRL, 32'h0);
    lock_req <= 1'b1;
    secure_is(1'b1);
    press(4'h1, 1'b1, 1'b1);
    ev(16'h0600);
    press(4'h2, 1'b1, 1'b1);
    ev(16'h0600);
    plock <= 1'b0;
    secure_is(1'b0);
    lock_req <= 1'b0;
    secure_is(1'b0);
    lock_req <= 1'b1;
    secure_is(1'b1);
    dc <= 1'b0;
    secure_is(1'b0);
    wr(OFS_CTRL, 32'h2);
    secure_is(1'b1);
    wr(OFS_CTRL, 32'h0);
    secure_is(1'b0);
    pb <= 4'h2;
    repeat (DEB + 4) @(posedge pclk);
    press(4'h3, 1'b0, 1'b1);
    ev(16'h1402);
    ev(16'h1400);
    ev(16'h1407);
    dc <= 1'b1;
    press(4'h8, 1'b1, 1'b1);
    ev(16'h1401);
    led_chk(2, 32'h1);
    repeat (IDC) @(posedge pclk);
    led_chk(2, 32'h0);
    press(4'h8, 1'b1, 1'b1);
    press(4'h8, 1'b1, 1'b1);
    led_chk(2, 32'h0);
    wr(OFS_IDENT, 32'h2);
    led_chk(2, 32'h1);
    wr(OFS_IDENT, 32'h1);
    led_chk(2, 32'h0);
    for (int i = 0; i < 9; i++) begin
      intr <= ht[i][10];
      wr(OFS_HEALTH, {26'h0, ht[i][9:4]});
      led_chk(1, {30'h0, ht[i][3:2]});
      led_chk(0, {30'h0, ht[i][1:0]});
    end
    evq.delete();
    wr(OFS_CTRL, 32'h10);
    intr <= 1'b0;
    ev(16'h0500);
    intr <= 1'b1;
    ev(16'h0500);
    summarize();
  end
endmodule // tb_top
